// file: liq_mem_model.sv
// memory-side model: takes vector writes from the queue writer and logs the last one
// assumes the writer runs on the same clock; slow_i makes it stall most cycles
`timescale 1ns/10ps
module liq_mem_model (
	input  wire logic                 clock_i, // system clock
	input  wire logic                 reset_i, // synchronous reset, high
	input  wire logic                 enable_i, // clock enable shared with the writer
	input  wire logic                 slow_i,  // stall three cycles in four
	input  wire logic                 valid_i, // write pending
	input  wire liq_pkg::liq_mem_wr_s wr_i,    // write address and data
	output logic                      ready_o, // write accepted
	output logic      [31:0]          addr_o,  // last address taken
	output logic      [31:0]          data_o,  // last dword taken
	output logic      [7:0]           count_o  // writes taken
);
	logic [1:0] phase;

	// ready pattern; a slow memory still accepts now and then, so it never stalls forever
	always_ff @(posedge clock_i)
	begin
		phase <= reset_i ? 2'h0 : phase + 2'h1;
		ready_o <= !reset_i && (!slow_i || phase == 2'h2);
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			count_o <= 8'h00;
		else if (enable_i && valid_i && ready_o)
		begin
			addr_o <= wr_i.addr;
			data_o <= wr_i.data;
			count_o <= count_o + 8'h01;
		end
	end
endmodule

// file: liq_pkg.sv
// shared constants, vector layout and carriers for the layer-two interrupt queue writer
// assumes a single 25 MHz clock domain; all users reference names as liq_pkg::name
package liq_pkg;

	// queue arrangement
	localparam int NUM_QUEUES      = 9;
	localparam int NUM_RINGS       = 8;
	localparam int CMD_QUEUE       = 8;
	localparam int HP_QUEUE        = 7;
	localparam int CMD_HALF_DWORDS = 256;
	localparam int CMD_LEN         = 2 * CMD_HALF_DWORDS;
	localparam int DWORD_SHIFT     = 2;

	// vector field positions
	localparam int VEC_DONE_BIT  = 31;
	localparam int VEC_TYPE_LSB  = 29;
	localparam int VEC_SUBG_LSB  = 27;
	localparam int VEC_QUEUE_LSB = 24;
	localparam int VEC_SYS_EXTRA_A_W    = 24;
	localparam int SUBG_PATH_BIT = 1;

	// type encodings
	localparam logic [1:0] TYPE_CMD  = 2'h0;
	localparam logic [1:0] TYPE_CHAN = 2'h1;
	localparam logic [1:0] TYPE_PORT = 2'h2;
	localparam logic [1:0] TYPE_SYS  = 2'h3;
	localparam logic [1:0] SUBG_SYS  = 2'h0;

	// system flag positions inside the vector, and pending index order
	localparam int SYS_FLAG_LSB    = 16;
	localparam int NUM_SYS         = 5;
	localparam int SYS_LANE_ERR    = 0;
	localparam int SYS_ACTION_WARN = 1;
	localparam int SYS_DATA_WARN   = 2;
	localparam int SYS_FAIL        = 3;
	localparam int SYS_MAILBOX     = 4;
	localparam int SYS_EXTRA_W     = 16;

	// host access check
	localparam logic [3:0] ALL_LANES = 4'hf;

	// reset values
	localparam logic [15:0] FAIL_COUNT_RST = 16'h0000;

	// request from a channel or port source
	typedef struct packed
	{
		logic [1:0]  subgroup;
		logic [2:0]  queue;
		logic [23:0] sys_extra_a;
	} liq_src_s;

	// one dword write toward system memory
	typedef struct packed
	{
		logic [31:0] addr;
		logic [31:0] data;
	} liq_mem_wr_s;

	// assembles a vector; the done bit always leaves set so the host can clear it
	function automatic logic [31:0] liq_pack_vec(input logic [1:0] vtype, input logic [1:0] subg,
		input logic [2:0] queue, input logic [23:0] sys_extra_a);
	begin
		liq_pack_vec = {1'b1, vtype, subg, queue, sys_extra_a};
	end
	endfunction

endpackage

// file: liq_ring_ptr.sv
// write offset of one interrupt queue ring, in dwords from its start address
// assumes advance_i pulses once per stored vector and length_i is stable while in use
`timescale 1ns/10ps
module liq_ring_ptr #(
	parameter int LEN_W = 16
) (
	input  wire logic             clock_i,   // system clock
	input  wire logic             reset_i,   // synchronous reset, high
	input  wire logic             enable_i,  // clock enable
	input  wire logic             advance_i, // one vector stored
	input  wire logic [LEN_W-1:0] length_i,  // ring size in dwords
	output logic      [LEN_W-1:0] offset_o   // current write offset
);

	logic last_slot;

	// a length of zero behaves as one slot rather than running off the ring
	assign last_slot = ({1'b0, offset_o} + {{LEN_W{1'b0}}, 1'b1}) >= {1'b0, length_i};

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			offset_o <= '0;
		else if (enable_i && advance_i)
			offset_o <= last_slot ? '0 : offset_o + {{(LEN_W-1){1'b0}}, 1'b1};
	end

	a_ring_wrap: assert property (@(posedge clock_i) disable iff (reset_i)
		(enable_i && advance_i && last_slot) |=> (offset_o == '0))
		else $error("ring offset did not wrap to start");

	a_ring_step: assert property (@(posedge clock_i) disable iff (reset_i)
		(enable_i && advance_i && !last_slot) |=> (offset_o == $past(offset_o) + 1'b1))
		else $error("ring offset did not step one dword");

endmodule

// file: liq_writer.sv
// layer-two interrupt controller: formats vectors and writes them into nine memory queues
// assumes all inputs come from logic on clock_i; memory side accepts a write with ready
//
// Summary of operation
// - a stored vector raises the host interrupt pin unless its queue is masked.
// - a per-queue status bit shows which queue received the new vector.
// - a masked queue still receives vectors but never raises the pin.
// - eight general queues are rings with programmable start and size.
// - command vectors go to queue eight, fixed at two halves of 256 dwords.
// - bit 31 of every vector is written as one; host may clear it later.
// - type 30:29, subgroup 28:27, queue 26:24, information 23:0.
// - type codes are command 00, channel 01, port 10, system 11.
// - upper subgroup bit tells transmit from receive path.
// - system vectors use type 11, subgroup 00, flags 20:16, extra 15:0.
// - a mailbox status write emits a system vector carrying that status.
// - discarded packets are counted; reaching threshold emits an access-failed vector.
// - data fill above threshold emits an early warning unless masked.
// - action queue above threshold emits an early warning under the same mask.
// - a host register access lacking any byte lane emits an access error vector.
// - the access error vector carries the attempted register address.
// - system vectors are generated only for sources left unmasked in sys_src_mask_i; channel, port and command requests have no such mask.
// - a high-priority mask redirects chosen channel vectors to queue seven.
`timescale 1ns/10ps
module liq_writer #(
	parameter int LEN_W  = 16,
	parameter int FILL_W = 16
) (
	input  wire logic                                  clock_i,            // 25 MHz clock
	input  wire logic                                  reset_i,            // synchronous reset, high
	input  wire logic                                  enable_i,           // clock enable
	input  wire logic                                  chan_valid_i,       // channel vector request
	input  wire liq_pkg::liq_src_s                     chan_req_i,         // channel vector content
	output logic                                       chan_take_o,        // channel request taken
	input  wire logic                                  port_valid_i,       // port vector request
	input  wire liq_pkg::liq_src_s                     port_req_i,         // port vector content
	output logic                                       port_take_o,        // port request taken
	input  wire logic                                  cmd_valid_i,        // command vector request
	input  wire logic [1:0]                            cmd_subgroup_i,     // command subgroup
	input  wire logic [23:0]                           cmd_sys_extra_a_i,         // command information
	output logic                                       cmd_take_o,         // command request taken
	input  wire logic                                  mail_status_wr_i,   // local side wrote mailbox status
	input  wire logic [15:0]                           local_to_host_mail_status_i, // mailbox status
	input  wire logic                                  rx_discard_i,       // one packet discarded
	input  wire logic [15:0]                           rx_fail_threshold_i, // discard threshold
	output logic      [15:0]                           rx_fail_counter_o,  // discarded packet count
	input  wire logic [FILL_W-1:0]                     rx_data_fill_i,     // receive data fill
	input  wire logic [FILL_W-1:0]                     rx_data_threshold_i, // data warn threshold
	input  wire logic [FILL_W-1:0]                     rx_action_fill_i,   // action queue fill
	input  wire logic [FILL_W-1:0]                     rx_action_threshold_i, // action warn threshold
	input  wire logic                                  rx_warn_mask_i,     // suppress early warnings
	input  wire logic                                  host_access_i,      // host register access
	input  wire logic [3:0]                            host_byte_en_i,     // its byte enables
	input  wire logic [15:0]                           host_addr_i,        // its register address
	input  wire logic [liq_pkg::NUM_SYS-1:0]           sys_src_mask_i,     // system source masks
	input  wire logic [2:0]                            sys_queue_i,        // queue for system vectors
	input  wire logic [liq_pkg::NUM_QUEUES-1:0][31:0]  queue_start_i,      // queue start addresses
	input  wire logic [liq_pkg::NUM_RINGS-1:0][LEN_W-1:0] queue_len_i,     // ring sizes in dwords
	input  wire logic [liq_pkg::NUM_QUEUES-1:0]        queue_mask_i,       // pin mask per queue
	input  wire logic [liq_pkg::NUM_RINGS-1:0]         hp_mask_i,          // redirect to queue seven
	input  wire logic [liq_pkg::NUM_QUEUES-1:0]        status_ack_i,       // clear status bits
	output logic                                       mem_wr_valid_o,     // memory write pending
	output liq_pkg::liq_mem_wr_s                       mem_wr_o,           // memory write address/data
	input  wire logic                                  mem_wr_ready_i,     // memory took the write
	output logic      [liq_pkg::NUM_QUEUES-1:0]        queue_status_o,     // queue holding new vector
	output logic                                       inta_o              // host interrupt pin level
);

	localparam int NQ = liq_pkg::NUM_QUEUES;
	localparam int NS = liq_pkg::NUM_SYS;

	// the command ring needs room for its fixed size
	if (LEN_W < 10 || LEN_W > 30)
		$error("LEN_W cannot hold the command queue size or an address offset");
	if (FILL_W < 1)
		$error("FILL_W must be positive");

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b01,
		ST_WRITE = 2'b10
	} liq_state_e;

	liq_state_e              state;
	logic [3:0]              cur_q;
	logic [NS-1:0]           sys_pend;
	logic [15:0]             mail_sys_extra_a;
	logic [15:0]             lane_sys_extra_a;
	logic                    data_over;
	logic                    action_over;
	logic [NQ-1:0]           advance;
	logic [NQ-1:0][LEN_W-1:0] offset;
	logic [NQ-1:0]           next_status;
	logic [NS-1:0]           sys_set;
	logic [NS-1:0]           sys_clr;
	logic                    write_done;
	logic [3:0]              next_q;
	logic [31:0]             next_vec;
	logic [2:0]              chan_q;
	logic                    pick;
	logic                    pick_cmd;
	logic                    pick_sys;
	logic                    pick_chan;
	logic                    pick_port;
	logic [2:0]              sys_idx;
	logic                    fail_hit;

	assign write_done = enable_i && (state == ST_WRITE) && mem_wr_ready_i;

	// ring offsets; queue eight runs on the fixed command size
	for (genvar g = 0; g < NQ; g++)
	begin : g_ring
		logic [LEN_W-1:0] len;
		if (g == liq_pkg::CMD_QUEUE)
			assign len = LEN_W'(liq_pkg::CMD_LEN);
		else
			assign len = queue_len_i[g];
		assign advance[g] = write_done && (cur_q == 4'(g));
		liq_ring_ptr #(
			.LEN_W    (LEN_W)
		) u_ptr (
			.clock_i   (clock_i),
			.reset_i   (reset_i),
			.enable_i  (enable_i),
			.advance_i (advance[g]),
			.length_i  (len),
			.offset_o  (offset[g])
		);
	end

	// system event detection
	// threshold compare
	assign fail_hit = rx_discard_i && (rx_fail_counter_o + 16'h0001 == rx_fail_threshold_i);

	always_comb
	begin
		sys_set = '0;
		sys_set[liq_pkg::SYS_MAILBOX] = mail_status_wr_i;
		sys_set[liq_pkg::SYS_FAIL] = fail_hit;
		sys_set[liq_pkg::SYS_DATA_WARN] = (rx_data_fill_i > rx_data_threshold_i) && !data_over && !rx_warn_mask_i;
		sys_set[liq_pkg::SYS_ACTION_WARN] = (rx_action_fill_i > rx_action_threshold_i) && !action_over
			&& !rx_warn_mask_i;
		sys_set[liq_pkg::SYS_LANE_ERR] = host_access_i && (host_byte_en_i != liq_pkg::ALL_LANES);
		sys_set = sys_set & ~sys_src_mask_i;
	end

	// discard counter saturates instead of wrapping back below the threshold
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			rx_fail_counter_o <= liq_pkg::FAIL_COUNT_RST;
		else if (enable_i && rx_discard_i && rx_fail_counter_o != 16'hffff)
			rx_fail_counter_o <= rx_fail_counter_o + 16'h0001;
	end

	// threshold history so each crossing warns once
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			data_over   <= 1'b0;
			action_over <= 1'b0;
		end
		else if (enable_i)
		begin
			data_over   <= rx_data_fill_i > rx_data_threshold_i;
			action_over <= rx_action_fill_i > rx_action_threshold_i;
		end
	end

	// extra information captured with its event
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			mail_sys_extra_a <= '0;
			lane_sys_extra_a <= '0;
		end
		else if (enable_i)
		begin
			if (sys_set[liq_pkg::SYS_MAILBOX])
				mail_sys_extra_a <= local_to_host_mail_status_i;
			if (sys_set[liq_pkg::SYS_LANE_ERR])
				lane_sys_extra_a <= host_addr_i;
		end
	end

	// highest pending system flag, mailbox first
	always_comb
	begin
		sys_idx = 3'h0;
		for (int i = 0; i < NS; i++)
			if (sys_pend[i])
				sys_idx = 3'(i);
	end

	// source choice: command, then system, then channel, then port
	assign pick      = enable_i && (state == ST_IDLE);
	assign pick_cmd  = pick && cmd_valid_i && !cmd_take_o;
	assign pick_sys  = pick && !pick_cmd && (sys_pend != '0);
	assign pick_chan = pick && !pick_cmd && !pick_sys && chan_valid_i && !chan_take_o;
	assign pick_port = pick && !pick_cmd && !pick_sys && !pick_chan && port_valid_i && !port_take_o;

	assign chan_q = hp_mask_i[chan_req_i.queue] ? 3'(liq_pkg::HP_QUEUE) : chan_req_i.queue;

	// vector assembly for the chosen source
	always_comb
	begin
		logic [15:0] extra;
		extra   = '0;
		next_q  = 4'h0;
		next_vec = '0;
		case (sys_idx)
			3'(liq_pkg::SYS_MAILBOX):     extra = mail_sys_extra_a;
			3'(liq_pkg::SYS_FAIL):        extra = rx_fail_counter_o;
			3'(liq_pkg::SYS_DATA_WARN):   extra = 16'(rx_data_fill_i);
			3'(liq_pkg::SYS_ACTION_WARN): extra = 16'(rx_action_fill_i);
			default:                      extra = lane_sys_extra_a;
		endcase
		if (pick_cmd)
		begin
			next_q   = 4'(liq_pkg::CMD_QUEUE);
			next_vec = liq_pkg::liq_pack_vec(liq_pkg::TYPE_CMD, cmd_subgroup_i, 3'h0, cmd_sys_extra_a_i);
		end
		else if (pick_sys)
		begin
			next_q   = {1'b0, sys_queue_i};
			next_vec = liq_pkg::liq_pack_vec(liq_pkg::TYPE_SYS, liq_pkg::SUBG_SYS, sys_queue_i,
				{3'h0, 5'(1 << sys_idx), extra});
		end
		else if (pick_chan)
		begin
			next_q   = {1'b0, chan_q};
			next_vec = liq_pkg::liq_pack_vec(liq_pkg::TYPE_CHAN, chan_req_i.subgroup, chan_q, chan_req_i.sys_extra_a);
		end
		else if (pick_port)
		begin
			next_q   = {1'b0, port_req_i.queue};
			next_vec = liq_pkg::liq_pack_vec(liq_pkg::TYPE_PORT, port_req_i.subgroup, port_req_i.queue,
				port_req_i.sys_extra_a);
		end
	end

	// pending system flags; a new event beats the clear of its own flag
	assign sys_clr = pick_sys ? NS'(1 << sys_idx) : '0;

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			sys_pend <= '0;
		else if (enable_i)
			sys_pend <= (sys_pend & ~sys_clr) | sys_set;
	end

	// take strobes are one cycle; sources drop valid on seeing them
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			cmd_take_o  <= 1'b0;
			chan_take_o <= 1'b0;
			port_take_o <= 1'b0;
		end
		else if (enable_i)
		begin
			cmd_take_o  <= pick_cmd;
			chan_take_o <= pick_chan;
			port_take_o <= pick_port;
		end
	end

	// ring address from start and offset
	// vector leaves with bit 31 set
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			state          <= ST_IDLE;
			cur_q          <= 4'h0;
			mem_wr_valid_o <= 1'b0;
			mem_wr_o       <= '0;
		end
		else if (enable_i)
		begin
			case (state)
				ST_IDLE:
					if (pick_cmd || pick_sys || pick_chan || pick_port)
					begin
						state          <= ST_WRITE;
						cur_q          <= next_q;
						mem_wr_valid_o <= 1'b1;
						mem_wr_o.addr  <= queue_start_i[next_q]
							+ 32'({offset[next_q], 2'b00});
						mem_wr_o.data  <= next_vec;
					end
				ST_WRITE:
					if (mem_wr_ready_i)
					begin
						state          <= ST_IDLE;
						mem_wr_valid_o <= 1'b0;
					end
				default:
				begin
					state          <= ST_IDLE;
					mem_wr_valid_o <= 1'b0;
				end
			endcase
		end
	end

	// status marks queue; set wins over ack
	always_comb
	begin
		next_status = queue_status_o & ~status_ack_i;
		if (write_done)
			next_status[cur_q] = 1'b1;
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			queue_status_o <= '0;
			inta_o         <= 1'b0;
		end
		else if (enable_i)
		begin
			queue_status_o <= next_status;
			inta_o         <= |(next_status & ~queue_mask_i);
		end
	end

	a_pin_after_write: assert property (@(posedge clock_i) disable iff (reset_i)
		(write_done && !queue_mask_i[cur_q] && enable_i) |=> inta_o)
		else $error("pin not raised after write to unmasked queue");

	a_masked_quiet: assert property (@(posedge clock_i) disable iff (reset_i)
		(enable_i && !write_done && ((queue_status_o & ~queue_mask_i) == '0)) |=> !inta_o)
		else $error("pin raised with only masked queues set");

	a_status_marks_queue: assert property (@(posedge clock_i) disable iff (reset_i)
		write_done |=> queue_status_o[$past(cur_q)])
		else $error("status bit missing for written queue");

	a_done_bit_set: assert property (@(posedge clock_i) disable iff (reset_i)
		mem_wr_valid_o |-> mem_wr_o.data[liq_pkg::VEC_DONE_BIT])
		else $error("vector written without bit 31");

	a_cmd_fixed_queue: assert property (@(posedge clock_i) disable iff (reset_i)
		(mem_wr_valid_o && mem_wr_o.data[30:29] == liq_pkg::TYPE_CMD) |-> (cur_q == 4'(liq_pkg::CMD_QUEUE)))
		else $error("command vector outside command queue");

	a_sys_layout: assert property (@(posedge clock_i) disable iff (reset_i)
		(mem_wr_valid_o && mem_wr_o.data[30:29] == liq_pkg::TYPE_SYS)
		|-> (mem_wr_o.data[28:27] == liq_pkg::SUBG_SYS && $onehot(mem_wr_o.data[20:16])))
		else $error("system vector layout wrong");

	a_hp_redirect: assert property (@(posedge clock_i) disable iff (reset_i)
		(pick_chan && hp_mask_i[chan_req_i.queue]) |=> (cur_q == 4'(liq_pkg::HP_QUEUE) && mem_wr_valid_o))
		else $error("high-priority channel vector not sent to queue seven");

	a_lane_error_sys_extra_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(enable_i && sys_set[liq_pkg::SYS_LANE_ERR]) |=> (lane_sys_extra_a == $past(host_addr_i)
		&& sys_pend[liq_pkg::SYS_LANE_ERR]))
		else $error("access error address not captured");

	a_fail_threshold: assert property (@(posedge clock_i) disable iff (reset_i)
		(enable_i && fail_hit && !sys_src_mask_i[liq_pkg::SYS_FAIL]) |=> sys_pend[liq_pkg::SYS_FAIL])
		else $error("threshold reached without access-failed event");

	a_warn_masked: assert property (@(posedge clock_i) disable iff (reset_i)
		(rx_warn_mask_i && !sys_pend[liq_pkg::SYS_DATA_WARN] && !sys_pend[liq_pkg::SYS_ACTION_WARN])
		|=> (!sys_pend[liq_pkg::SYS_DATA_WARN] && !sys_pend[liq_pkg::SYS_ACTION_WARN]))
		else $error("early warning raised while masked");

endmodule

// file: tb.sv
// self-checking bench for the interrupt queue writer, one task per scenario
// assumes the writer and the memory model share one 25 MHz clock
`timescale 1ns/10ps
module tb;
	logic                 clock_i, reset_i, enable_i, chan_valid_i, port_valid_i, cmd_valid_i, slow;
	logic                 mail_status_wr_i, rx_discard_i, rx_warn_mask_i, host_access_i, inta_o;
	logic                 chan_take_o, port_take_o, cmd_take_o, mem_wr_valid_o, mem_wr_ready_i;
	liq_pkg::liq_src_s    chan_req_i, port_req_i;
	liq_pkg::liq_mem_wr_s mem_wr_o;
	logic [1:0]           cmd_subgroup_i;
	logic [23:0]          cmd_sys_extra_a_i;
	logic [15:0]          local_to_host_mail_status_i, rx_fail_threshold_i, rx_fail_counter_o, host_addr_i;
	logic [15:0]          rx_data_fill_i, rx_data_threshold_i, rx_action_fill_i, rx_action_threshold_i;
	logic [3:0]           host_byte_en_i;
	logic [4:0]           sys_src_mask_i;
	logic [2:0]           sys_queue_i;
	logic [8:0][31:0]     queue_start_i;
	logic [7:0][15:0]     queue_len_i;
	logic [8:0]           queue_mask_i, status_ack_i, queue_status_o;
	logic [7:0]           hp_mask_i, seen_n, n_seen;
	logic [31:0]          seen_a, seen_d;
	int                   fails, n_checks, sys_off;

	liq_writer dut_u (.clock_i, .reset_i, .enable_i, .chan_valid_i, .chan_req_i, .chan_take_o, .port_valid_i,
		.port_req_i, .port_take_o, .cmd_valid_i, .cmd_subgroup_i, .cmd_sys_extra_a_i, .cmd_take_o, .mail_status_wr_i,
		.local_to_host_mail_status_i, .rx_discard_i, .rx_fail_threshold_i, .rx_fail_counter_o, .rx_data_fill_i,
		.rx_data_threshold_i, .rx_action_fill_i, .rx_action_threshold_i, .rx_warn_mask_i, .host_access_i,
		.host_byte_en_i, .host_addr_i, .sys_src_mask_i, .sys_queue_i, .queue_start_i, .queue_len_i,
		.queue_mask_i, .hp_mask_i, .status_ack_i, .mem_wr_valid_o, .mem_wr_o, .mem_wr_ready_i,
		.queue_status_o, .inta_o);
	liq_mem_model mem_u (.clock_i, .reset_i, .slow_i(slow), .valid_i(mem_wr_valid_o), .wr_i(mem_wr_o),
		.enable_i, .ready_o(mem_wr_ready_i), .addr_o(seen_a), .data_o(seen_d), .count_o(seen_n));

	// free-running 40 ns clock
	always #20 clock_i = ~clock_i;

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// waits bounded for one logged write, judges it, and returns on a rising edge for the next drive
	task vec(input logic [31:0] a, input logic [31:0] d);
		for (int k = 0; k < 80 && seen_n === n_seen; k++) @(negedge clock_i);
		chk("count", 32'(n_seen + 8'h01), 32'(seen_n));
		n_seen = seen_n;
		chk("addr", a, seen_a);
		chk("data", d, seen_d);
		@(posedge clock_i);
	endtask

	task no_vec;
		repeat (20) @(posedge clock_i);
		chk("silent", 32'(n_seen), 32'(seen_n));
	endtask

	task sys_vec(input logic [4:0] f, input logic [15:0] x);
		vec(queue_start_i[5] + 32'(4 * sys_off), {1'b1, 2'h3, 2'h0, 3'h5, 3'h0, f, x});
		sys_off++;
	endtask

	// src 0 channel, 1 port, 2 command; valid held until taken
	task req(input int src, input logic [1:0] s, input logic [2:0] q, input logic [23:0] i);
		@(posedge clock_i);
		chan_req_i <= '{s, q, i};
		port_req_i <= '{s, q, i};
		{cmd_subgroup_i, cmd_sys_extra_a_i} <= {s, i};
		{chan_valid_i, port_valid_i, cmd_valid_i} <= {src == 0, src == 1, src == 2};
		for (int k = 0; k < 80 && {chan_take_o, port_take_o, cmd_take_o} === 3'h0; k++) @(negedge clock_i);
		chk("take", 32'({src == 0, src == 1, src == 2}), 32'({chan_take_o, port_take_o, cmd_take_o}));
		@(posedge clock_i);
		{chan_valid_i, port_valid_i, cmd_valid_i} <= 3'h0;
	endtask

	// w 0 mailbox write, 1 discard, 2 host access
	task evt(input int w);
		@(posedge clock_i);
		{mail_status_wr_i, rx_discard_i, host_access_i} <= {w == 0, w == 1, w == 2};
		@(posedge clock_i);
		{mail_status_wr_i, rx_discard_i, host_access_i} <= 3'h0;
	endtask

	// pin and status after a vector, then acknowledge everything
	task pin(input int q, input logic p);
		repeat (3) @(posedge clock_i);
		chk("status", 32'(9'h001 << q), 32'(queue_status_o));
		chk("pin", 32'(p), 32'(inta_o));
		status_ack_i <= 9'h1ff;
		@(posedge clock_i);
		status_ack_i <= 9'h000;
		repeat (3) @(posedge clock_i);
		chk("cleared", 32'h0, 32'({queue_status_o, inta_o}));
	endtask

	// clock enable low freezes picking; the waiting request goes once enable returns
	task t_freeze;
		chan_req_i <= '{2'h0, 3'h0, 24'h0000aa};
		{chan_valid_i, enable_i} <= 2'b10;
		repeat (6) @(posedge clock_i);
		chk("frozen take", 32'h0, 32'(chan_take_o));
		chk("frozen write", 32'(n_seen), 32'(seen_n));
		enable_i <= 1'b1;
		req(0, 2'h0, 3'h0, 24'h0000aa);
		vec(queue_start_i[0], {1'b1, 2'h1, 2'h0, 3'h0, 24'h0000aa});
		pin(0, 1'b1);
	endtask

	task t_sources;
		req(0, 2'h2, 3'h2, 24'habcdef);
		vec(queue_start_i[2], {1'b1, 2'h1, 2'h2, 3'h2, 24'habcdef});
		pin(2, 1'b1);
		req(1, 2'h1, 3'h4, 24'h123456);
		vec(queue_start_i[4], {1'b1, 2'h2, 2'h1, 3'h4, 24'h123456});
		pin(4, 1'b1);
		req(2, 2'h1, 3'h0, 24'h00beef);
		vec(queue_start_i[8], {1'b1, 2'h0, 2'h1, 3'h0, 24'h00beef});
		pin(8, 1'b1);
		queue_mask_i <= 9'h040;
		req(0, 2'h0, 3'h6, 24'h000066);
		vec(queue_start_i[6], {1'b1, 2'h1, 2'h0, 3'h6, 24'h000066});
		pin(6, 1'b0);
		queue_mask_i <= 9'h000;
		hp_mask_i <= 8'h08;
		req(0, 2'h1, 3'h3, 24'h000777);
		vec(queue_start_i[7], {1'b1, 2'h1, 2'h1, 3'h7, 24'h000777});
		pin(7, 1'b1);
		hp_mask_i <= 8'h00;
	endtask

	// ring of two dwords under a stalling memory
	task t_ring;
		queue_len_i[1] <= 16'h0002;
		slow <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			req(0, 2'h0, 3'h1, 24'(k));
			vec(queue_start_i[1] + 32'(4 * (k % 2)), {1'b1, 2'h1, 2'h0, 3'h1, 24'(k)});
		end
		slow <= 1'b0;
		pin(1, 1'b1);
	endtask

	task t_system;
		local_to_host_mail_status_i <= 16'h5a5a;
		evt(0);
		sys_vec(5'h10, 16'h5a5a);
		evt(1);
		evt(1);
		no_vec;
		evt(1);
		sys_vec(5'h08, 16'h0003);
		chk("fail count", 32'h3, 32'(rx_fail_counter_o));
		rx_data_fill_i <= 16'h0004;
		no_vec;
		rx_data_fill_i <= 16'h0005;
		sys_vec(5'h04, 16'h0005);
		{rx_data_fill_i, rx_warn_mask_i, rx_action_fill_i} <= {16'h0, 1'b1, 16'h9};
		no_vec;
		{rx_warn_mask_i, rx_action_fill_i} <= {1'b0, 16'h0};
		repeat (3) @(posedge clock_i);
		rx_action_fill_i <= 16'h0009;
		sys_vec(5'h02, 16'h0009);
		{host_byte_en_i, host_addr_i} <= {4'hf, 16'h0124};
		evt(2);
		no_vec;
		host_byte_en_i <= 4'h7;
		evt(2);
		sys_vec(5'h01, 16'h0124);
		pin(5, 1'b1);
	endtask

	// stimulus and verdict
	initial
	begin
		{clock_i, reset_i, enable_i, slow, n_seen, fails, n_checks, sys_off} = {3'h3, 9'h0, 96'h0};
		{chan_valid_i, port_valid_i, cmd_valid_i, mail_status_wr_i, rx_discard_i, host_access_i} = 6'h0;
		{chan_req_i, port_req_i, cmd_subgroup_i, cmd_sys_extra_a_i, local_to_host_mail_status_i} = '0;
		{rx_fail_threshold_i, rx_data_fill_i, rx_data_threshold_i} = {16'h3, 16'h0, 16'h4};
		{rx_action_fill_i, rx_action_threshold_i, rx_warn_mask_i} = {16'h0, 16'h8, 1'b0};
		{host_byte_en_i, host_addr_i, sys_src_mask_i, sys_queue_i} = {4'h3, 16'h0040, 5'h1f, 3'h5};
		{queue_mask_i, status_ack_i, hp_mask_i} = '0;
		queue_len_i = {8{16'h0010}};
		for (int q = 0; q < 9; q++) queue_start_i[q] = 32'h1000 * q;
		repeat (8) @(posedge clock_i);
		reset_i <= 1'b0;
		evt(0);
		evt(2);
		no_vec;
		sys_src_mask_i <= 5'h00;
		t_freeze();
		t_sources();
		t_ring();
		t_system();
		close_out();
	end

	// hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clock_i);
		fails++;
		close_out();
	end
endmodule
